// ### logic/smlvw_ctrl.sv
// Function
// (R1) bit 4 reads 1 after recovery from full power-down stop, else 0.
// (R2) bit 3 reads 1 after recovery from partial power-down stop, else 0.
// (R3) writing 1 to bit 2 clears both recovery flags together.
// (R4) bit 1 forbids power-down entry at 0, allows selected mode at 1.
// (R5) bit 0 picks full power down at 0, partial at 1.
// (R6) write-once bits take the first write after reset, later writes ignored.
// (R7) warning flag bit 7 is sticky: set while warning, held until cleared.
// (R8) flag sets when supply below warning point, also right after reset.
// (R9) writing 1 to bit 6 clears flag only when no warning present.
// (R10) bit 5 picks detect trip point: 0 low, 1 high.
// (R11) bit 4 of warning register picks warning trip point: 0 low, 1 high.
// (R12) power-on reset clears both trip selects; other resets leave them.
// (R13) software acknowledges after partial power-down restore before pin access.
// (R14) warning level is synchronized; set beats simultaneous acknowledge.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smlvw_ctrl
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          clk_en,
   input  wire logic          reset_is_por,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // power controller and comparator
   input  wire logic          supply_warning_async,
   input  wire logic          full_power_down_recovered,
   input  wire logic          partial_power_down_recovered,
   input  wire logic          stop_request,
   output logic               enter_full_power_down_stop,
   output logic               enter_partial_power_down_stop,
   output logic               power_down_entry_enable,
   output smlvw_pkg::smlvw_mode_type power_down_mode_select,
   output logic               detect_trip_select,
   output logic               warning_trip_select,
   output logic               irq
);
   import smlvw_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   smlvw_sense_if sense ();

   logic                full_pd_flag_q;
   logic                partial_pd_flag_q;
   logic                pd_enable_q;
   smlvw_mode_type      pd_mode_q;
   logic                write_once_lock_q;
   logic                warn_flag_q;
   logic                detect_trip_q;
   logic                warn_trip_q;
   logic [IRQ_W-1:0]    irq_status_q;
   logic [IRQ_W-1:0]    irq_mask_q;
   logic [IRQ_W-1:0]    irq_events;
   logic [31:0]         prdata_q;
   logic [31:0]         read_word;
   logic                enter_full_q;
   logic                enter_partial_q;
   logic                setup_phase;
   logic                access_phase;
   logic                wr_en;
   logic                addr_hit;
   logic                wr_stop;
   logic                wr_warn;
   logic                wr_status;
   logic                wr_mask;
   logic                pd_ack;
   logic                warn_ack;
   logic                warn_set;
   logic                recover_event;

   ////////////////////////////////////////////////////////////////////////
   // comparator synchronizer
   smlvw_sync u_sync
   (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .clk_en     (clk_en),
      .warn_async (supply_warning_async),
      .sense      (sense.src)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states while clock enable is high
   assign setup_phase  = psel && !penable && clk_en;
   assign access_phase = psel && penable;
   assign pready       = clk_en;
   assign wr_en        = access_phase && pwrite && clk_en;

   // address decode
   always_comb
   begin
      addr_hit = 1'b1;
      unique case (paddr)
         STOP_CTRL_OFFSET, WARN_CTRL_OFFSET,
         IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET: addr_hit = 1'b1;
         default:                            addr_hit = 1'b0;
      endcase
   end

   // unmapped addresses answer with an error
   assign pslverr   = access_phase && !addr_hit;

   // per-register write strobes
   assign wr_stop   = wr_en && (paddr == STOP_CTRL_OFFSET);
   assign wr_warn   = wr_en && (paddr == WARN_CTRL_OFFSET);
   assign wr_status = wr_en && (paddr == IRQ_STATUS_OFFSET);
   assign wr_mask   = wr_en && (paddr == IRQ_MASK_OFFSET);

   // acknowledge strobes; the ack bits themselves are never stored
   assign pd_ack    = wr_stop && pwdata[PD_ACK_BIT];
   assign warn_ack  = wr_warn && pwdata[WARN_ACK_BIT];

   ////////////////////////////////////////////////////////////////////////
   // stop mode recovery flags
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         full_pd_flag_q    <= BIT_RESET;
         partial_pd_flag_q <= BIT_RESET;
      end
      else if (clk_en)
      begin
         // a recovery event in the ack cycle wins
         if (full_power_down_recovered)
            full_pd_flag_q <= 1'b1; // R1
         else if (pd_ack)
            full_pd_flag_q <= 1'b0; // R3
         if (partial_power_down_recovered)
            partial_pd_flag_q <= 1'b1; // R2
         else if (pd_ack)
            partial_pd_flag_q <= 1'b0; // R3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write-once power-down controls
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pd_enable_q       <= BIT_RESET;
         pd_mode_q         <= SMLVW_MODE_FULL;
         write_once_lock_q <= BIT_RESET;
      end
      else if (clk_en && wr_stop && !write_once_lock_q)
      begin
         pd_enable_q       <= pwdata[PD_ENABLE_BIT]; // R6
         pd_mode_q         <= smlvw_mode_type'(pwdata[PD_MODE_BIT]); // R6
         write_once_lock_q <= 1'b1; // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stop entry steering
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         enter_full_q    <= BIT_RESET;
         enter_partial_q <= BIT_RESET;
      end
      else if (clk_en)
      begin
         enter_full_q    <= stop_request && pd_enable_q &&
                            (pd_mode_q == SMLVW_MODE_FULL); // R4 R5
         enter_partial_q <= stop_request && pd_enable_q &&
                            (pd_mode_q == SMLVW_MODE_PARTIAL); // R4 R5
      end
   end

   assign enter_full_power_down_stop    = enter_full_q;
   assign enter_partial_power_down_stop = enter_partial_q;
   assign power_down_entry_enable       = pd_enable_q;
   assign power_down_mode_select        = pd_mode_q;

   ////////////////////////////////////////////////////////////////////////
   // sticky low-voltage warning flag
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         warn_flag_q <= BIT_RESET;
      end
      else if (clk_en)
      begin
         // live level re-sets the flag after reset too
         if (sense.warn_level)
            warn_flag_q <= 1'b1; // R7 R8 R14
         else if (warn_ack)
            warn_flag_q <= 1'b0; // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trip point selects, cleared only by power-on reset
   always_ff @(posedge clk_sys)
   begin
      if (rst && reset_is_por)
      begin
         detect_trip_q <= BIT_RESET; // R12
         warn_trip_q   <= BIT_RESET; // R12
      end
      else if (!rst && clk_en && wr_warn)
      begin
         detect_trip_q <= pwdata[DETECT_TRIP_BIT]; // R10
         warn_trip_q   <= pwdata[WARN_TRIP_BIT]; // R11
      end
   end

   assign detect_trip_select  = detect_trip_q;
   assign warning_trip_select = warn_trip_q;

   ////////////////////////////////////////////////////////////////////////
   // interrupt events: flag rising and any stop recovery
   assign warn_set      = sense.warn_level && !warn_flag_q;
   assign recover_event = full_power_down_recovered || partial_power_down_recovered;
   assign irq_events    = {recover_event, warn_set};

   // sticky status, write one to clear, set wins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_status_q <= IRQ_RESET;
      end
      else if (clk_en)
      begin
         irq_status_q <= irq_events |
                         (irq_status_q & ~(wr_status ? pwdata[IRQ_W-1:0] : IRQ_RESET));
      end
   end

   // interrupt mask
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_mask_q <= IRQ_RESET;
      end
      else if (clk_en && wr_mask)
      begin
         irq_mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // level interrupt
   assign irq = |(irq_status_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////
   // read mux; ack bits and reserved bits read as zero
   always_comb
   begin
      read_word = RDATA_RESET;
      unique case (paddr)
         STOP_CTRL_OFFSET:
         begin
            read_word[FULL_PD_FLAG_BIT]    = full_pd_flag_q; // R1
            read_word[PARTIAL_PD_FLAG_BIT] = partial_pd_flag_q; // R2
            read_word[PD_ENABLE_BIT]       = pd_enable_q;
            read_word[PD_MODE_BIT]         = pd_mode_q;
         end
         WARN_CTRL_OFFSET:
         begin
            read_word[WARN_FLAG_BIT]       = warn_flag_q; // R7
            read_word[DETECT_TRIP_BIT]     = detect_trip_q;
            read_word[WARN_TRIP_BIT]       = warn_trip_q;
         end
         IRQ_STATUS_OFFSET: read_word[IRQ_W-1:0] = irq_status_q;
         IRQ_MASK_OFFSET:   read_word[IRQ_W-1:0] = irq_mask_q;
         default:           read_word = RDATA_RESET;
      endcase
   end

   // read data captured in the setup cycle
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         prdata_q <= RDATA_RESET;
      end
      else if (setup_phase && !pwrite)
      begin
         prdata_q <= read_word;
      end
   end

   assign prdata = prdata_q;

endmodule : smlvw_ctrl
`default_nettype wire

// ### logic/smlvw_pkg.sv
`default_nettype none
package smlvw_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses of aligned 32-bit words
   localparam logic [7:0] STOP_CTRL_OFFSET  = 8'h00;
   localparam logic [7:0] WARN_CTRL_OFFSET  = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h0C;

   ////////////////////////////////////////////////////////////////////////
   // stop_power_down_ctrl_status fields
   localparam int FULL_PD_FLAG_BIT    = 4;
   localparam int PARTIAL_PD_FLAG_BIT = 3;
   localparam int PD_ACK_BIT          = 2;
   localparam int PD_ENABLE_BIT       = 1;
   localparam int PD_MODE_BIT         = 0;

   ////////////////////////////////////////////////////////////////////////
   // low_voltage_warning_ctrl_status fields
   localparam int WARN_FLAG_BIT       = 7;
   localparam int WARN_ACK_BIT        = 6;
   localparam int DETECT_TRIP_BIT     = 5;
   localparam int WARN_TRIP_BIT       = 4;

   ////////////////////////////////////////////////////////////////////////
   // interrupt status and mask fields
   localparam int IRQ_WARN_BIT        = 0;
   localparam int IRQ_RECOVER_BIT     = 1;
   localparam int IRQ_W               = 2;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [IRQ_W-1:0] IRQ_RESET     = 2'h0;
   localparam logic             BIT_RESET     = 1'b0;
   localparam logic [31:0]      RDATA_RESET   = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // power-down mode encoding of the mode select bit
   typedef enum logic
   {
      SMLVW_MODE_FULL    = 1'b0,
      SMLVW_MODE_PARTIAL = 1'b1
   } smlvw_mode_type;

endpackage : smlvw_pkg
`default_nettype wire

// ### logic/smlvw_sense_if.sv
`timescale 1ns/1ps
`default_nettype none
// synchronized comparator levels from the sync stage to the controller
interface smlvw_sense_if;
   logic warn_level;

   modport src
   (
      output warn_level
   );

   modport dst
   (
      input warn_level
   );
endinterface : smlvw_sense_if
`default_nettype wire

// ### logic/smlvw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module smlvw_sync
(
   input  wire logic    clk_sys,
   input  wire logic    rst,
   input  wire logic    clk_en,
   input  wire logic    warn_async,
   smlvw_sense_if.src   sense
);
   import smlvw_pkg::*;

   logic stage1_q;
   logic stage2_q;

   ////////////////////////////////////////////////////////////////////////
   // two flops; stage1 is read only by stage2
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         stage1_q <= BIT_RESET;
         stage2_q <= BIT_RESET;
      end
      else if (clk_en)
      begin
         stage1_q <= warn_async; // R14
         stage2_q <= stage1_q;
      end
   end

   // level handed to the controller
   assign sense.warn_level = stage2_q;

endmodule : smlvw_sync
`default_nettype wire

// ### verif/smlvw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module smlvw_monitor
   import smlvw_pkg::*;
(
   input wire logic                      clk_sys,
   input wire logic                      rst,
   input wire logic                      clk_en,
   input wire logic                      reset_is_por,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      stop_request,
   input wire logic                      enter_full_power_down_stop,
   input wire logic                      enter_partial_power_down_stop,
   input wire logic                      power_down_entry_enable,
   input wire smlvw_pkg::smlvw_mode_type power_down_mode_select,
   input wire logic                      detect_trip_select,
   input wire logic                      warning_trip_select
);
   default clocking cb @(posedge clk_sys); endclocking
   logic acc;
   logic lock_q;
   // access phase accepted
   assign acc = psel && penable && clk_en;
   // set by the first stop control write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         lock_q <= 1'b0;
      else if (acc && pwrite && paddr == STOP_CTRL_OFFSET)
         lock_q <= 1'b1;
   end
   ////////////////////////////////////////
   full_entry_a: assert property (disable iff (rst)
      clk_en && stop_request && power_down_entry_enable && power_down_mode_select == SMLVW_MODE_FULL
      |=> enter_full_power_down_stop && !enter_partial_power_down_stop) else $error("no full entry");
   partial_entry_a: assert property (disable iff (rst)
      clk_en && stop_request && power_down_entry_enable && power_down_mode_select != SMLVW_MODE_FULL
      |=> enter_partial_power_down_stop && !enter_full_power_down_stop) else $error("no partial entry");
   entry_blocked_a: assert property (disable iff (rst) clk_en && !power_down_entry_enable
      |=> !enter_full_power_down_stop && !enter_partial_power_down_stop) else $error("entry while off");
   write_once_a: assert property (disable iff (rst) lock_q
      |=> $stable(power_down_entry_enable) && $stable(power_down_mode_select)) else $error("relocked");
   trip_por_a: assert property (rst && reset_is_por
      |=> !detect_trip_select && !warning_trip_select) else $error("trip not cleared");
   trip_keep_a: assert property (rst && !reset_is_por
      |=> $stable(detect_trip_select) && $stable(warning_trip_select)) else $error("trip lost");
   stop_read_a: assert property (disable iff (rst) acc && !pwrite && paddr == STOP_CTRL_OFFSET
      |-> prdata[2:0] == {1'b0, power_down_entry_enable, power_down_mode_select}) else $error("stop rd");
   warn_read_a: assert property (disable iff (rst) acc && !pwrite && paddr == WARN_CTRL_OFFSET
      |-> prdata[6:0] == {1'b0, detect_trip_select, warning_trip_select, 4'h0}) else $error("warn rd");
   unmapped_err_a: assert property (disable iff (rst) acc && !pwrite && paddr[7:4] != 4'h0
      |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access");
   ready_follow_a: assert property (disable iff (rst) psel |-> pready == clk_en) else $error("pready");
   // main scenarios
   full_entry_c: cover property (enter_full_power_down_stop);
   partial_entry_c: cover property (enter_partial_power_down_stop);
   soft_reset_c: cover property (rst && !reset_is_por && warning_trip_select);
endmodule : smlvw_monitor
`default_nettype wire

// ### verif/smlvw_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module smlvw_ctrl_tb_top;
   import smlvw_pkg::*;
   logic           clk_sys = 0, rst = 1, por = 1, psel = 0, penable = 0, pwrite = 0;
   logic           warn = 0, frec = 0, prec = 0, sreq = 0, err, efull, epart, irq;
   logic           ce = 1, rdy, re, pden, dts, wts;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0, prdata, rd, t;
   smlvw_mode_type pdmode;
   integer         seed = 11615;
   int             errors = 0, num_checks = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   smlvw_ctrl uut (.clk_sys(clk_sys), .rst(rst), .clk_en(ce), .reset_is_por(por),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(rdy), .pslverr(err), .supply_warning_async(warn),
      .full_power_down_recovered(frec), .partial_power_down_recovered(prec),
      .stop_request(sreq), .enter_full_power_down_stop(efull),
      .enter_partial_power_down_stop(epart), .power_down_entry_enable(pden),
      .power_down_mode_select(pdmode), .detect_trip_select(dts),
      .warning_trip_select(wts), .irq(irq));
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic f, input logic p, input logic e, input logic m);
      return {27'h0, f, p, 1'b0, e, m};
   endfunction : xs
   function automatic logic [31:0] xw(input logic f, input logic d, input logic w);
      return {24'h0, f, 1'b0, d, w, 4'h0};
   endfunction : xw
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value at %0t: exp %h got %h", $time, e, g);
      end
   endtask : chk
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (rdy !== 1'b1);
      rd = prdata;
      re = err;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic do_rst(input logic p);
      @(posedge clk_sys);
      por <= p;
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
   endtask : do_rst
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         errors++;
         end_of_test();
      end
   end
   ////////////////////////////////////////
   initial
   begin
      do_rst(1'b1);
      apb(0, STOP_CTRL_OFFSET, 0);
      chk(0, rd);
      for (int i = 0; i < 4; i++)
      begin
         do_rst(1'b0);
         apb(1, STOP_CTRL_OFFSET, 32'(i));
         apb(1, STOP_CTRL_OFFSET, $random(seed));
         apb(0, STOP_CTRL_OFFSET, 0);
         chk(xs(0, 0, i[1], i[0]), rd);
         sreq <= 1'b1;
         @(posedge clk_sys);
         sreq <= 1'b0;
         #1;
         chk({30'h0, i == 2, i == 3}, {30'h0, efull, epart});
      end
      chk(32'h3, {30'h0, pden, pdmode});
      apb(0, IRQ_MASK_OFFSET, 0);
      frec <= 1'b1;
      @(posedge clk_sys);
      frec <= 1'b0;
      apb(0, STOP_CTRL_OFFSET, 0);
      chk(xs(1, 0, 1, 1), rd);
      chk({31'h0, irq}, 0);
      // one-cycle recovery pulse
      prec <= 1'b1;
      @(posedge clk_sys);
      prec <= 1'b0;
      apb(1, IRQ_MASK_OFFSET, 2);
      apb(0, STOP_CTRL_OFFSET, 0);
      chk(xs(1, 1, 1, 1), rd);
      chk({31'h0, irq}, 1);
      apb(1, STOP_CTRL_OFFSET, 4);
      apb(1, IRQ_STATUS_OFFSET, 2);
      apb(0, STOP_CTRL_OFFSET, 0);
      chk(xs(0, 0, 1, 1), rd);
      chk({31'h0, irq}, 0);
      // recovery pulse while the clock enable is low must be lost
      ce <= 1'b0;
      frec <= 1'b1;
      @(posedge clk_sys);
      frec <= 1'b0;
      ce <= 1'b1;
      apb(0, STOP_CTRL_OFFSET, 0);
      chk(xs(0, 0, 1, 1), rd);
      warn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      apb(0, WARN_CTRL_OFFSET, 0);
      chk(xw(1, 0, 0), rd);
      apb(0, IRQ_STATUS_OFFSET, 0);
      chk(32'h1, rd);
      t = $random(seed) & 32'h30;
      apb(1, WARN_CTRL_OFFSET, t | 32'h40);
      apb(0, WARN_CTRL_OFFSET, 0);
      chk(xw(1, t[5], t[4]), rd);
      chk({31'h0, t[5]}, {31'h0, dts});
      chk({31'h0, t[4]}, {31'h0, wts});
      warn <= 1'b0;
      repeat (5) @(posedge clk_sys);
      apb(0, WARN_CTRL_OFFSET, 0);
      chk(xw(1, t[5], t[4]), rd);
      apb(1, WARN_CTRL_OFFSET, t | 32'h40);
      apb(0, WARN_CTRL_OFFSET, 0);
      chk(xw(0, t[5], t[4]), rd);
      warn <= 1'b1;
      do_rst(1'b0);
      repeat (4) @(posedge clk_sys);
      apb(0, WARN_CTRL_OFFSET, 0);
      chk(xw(1, t[5], t[4]), rd);
      do_rst(1'b1);
      repeat (4) @(posedge clk_sys);
      apb(0, WARN_CTRL_OFFSET, 0);
      chk(xw(1, 0, 0), rd);
      apb(0, 8'h10, 0);
      chk(32'h8000_0000, {re, rd[30:0]});
      end_of_test();
   end
endmodule : smlvw_ctrl_tb_top
bind smlvw_ctrl smlvw_monitor mon (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
   .reset_is_por(reset_is_por), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .stop_request(stop_request), .enter_full_power_down_stop(enter_full_power_down_stop),
   .enter_partial_power_down_stop(enter_partial_power_down_stop),
   .power_down_entry_enable(power_down_entry_enable),
   .power_down_mode_select(power_down_mode_select),
   .detect_trip_select(detect_trip_select), .warning_trip_select(warning_trip_select));
`default_nettype wire
